/* File: design/fdl_blink.v */
`timescale 1ns/1ps
`include "fdl_defines.vh"
// Free running divider; toggles phase every half period
module fdl_blink #(
    parameter HALF_CYC = `FDL_BLINK_CYC
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Output
    output reg phase_q
);
    reg [31:0] cnt_q;

    always @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= 32'h0;
            phase_q <= 1'b0;
        end else if (cnt_q >= HALF_CYC - 1) begin
            cnt_q <= 32'h0;
            phase_q <= ~phase_q;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule

/* File: design/fdl_defines.vh */
`ifndef FDL_DEFINES_VH
`define FDL_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FDL_OFF_CTRL 12'h000
`define FDL_OFF_MODE 12'h004
`define FDL_OFF_FAULT 12'h008
`define FDL_OFF_CMDW 12'h00c
`define FDL_OFF_STAT 12'h010

// ----------------------------------------
// Error response settings
// ----------------------------------------
`define FDL_RSP_FREEWHEEL 3'h0
`define FDL_RSP_RAMP 3'h1
`define FDL_RSP_FAST 3'h2
`define FDL_RSP_DCINJ 3'h3
`define FDL_RSP_IGNORE 3'h4
`define FDL_RSP_PERSTT 3'h5
`define FDL_RSP_FALLBACK 3'h6
`define FDL_RSP_MAINTAIN 3'h7
`define FDL_RSP_RESET 3'h0

// ----------------------------------------
// Control mode select
// ----------------------------------------
`define FDL_MODE_COMBINED 2'h0
`define FDL_MODE_SPLIT 2'h1
`define FDL_MODE_IO 2'h2
`define FDL_MODE_RESET 2'h0

// Source selects
`define FDL_SRC_ETH 1'b1
`define FDL_SRC_HMI 1'b0

// ----------------------------------------
// Fault codes
// ----------------------------------------
`define FDL_ETH_TIMEOUT 4'h1
`define FDL_EXT_BAD_IP 4'h1
`define FDL_EXT_DUP_IP 4'h2
`define FDL_EXT_REPL 4'h4

// I/O profile command word bits
`define FDL_IO_FWD 0
`define FDL_IO_REV 1
`define FDL_IO_RST 7

// ----------------------------------------
// LED colours {green, red_or_yellow}
// ----------------------------------------
`define FDL_LED_OFF 2'h0
`define FDL_LED_GRN 2'h2
`define FDL_LED_ALT 2'h1

// Blink half period in ns and cycles at 20 MHz
`define FDL_BLINK_NS 250000000
`define FDL_CLK_NS 50
`define FDL_BLINK_CYC (`FDL_BLINK_NS / `FDL_CLK_NS)

`endif

/* File: design/fdl_diag.v */
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "fdl_defines.vh"
// How it works
// - While interruption active, code register holds cause; 1 means Modbus TCP timeout.
// - Internal fault flag is sticky until power off; nothing clears it.
// - External fault code: 1 invalid IP, 2 duplicate IP, 4 replacement failure.
// - Ignore response disables monitoring; no interruption fault raised.
// - Control mode select picks combined, split or I/O profile.
// - Split with Ethernet command and HMI reference: network word, local reference.
// - Link LED off without link, steady green 100M, steady yellow 10M.
// - Link LED blinks on traffic by speed; alternates during power-on test.
// - Network LED off without IP; alternates green/red during power-on test.
// - Network LED steady green with command connection, blinks green otherwise.
// - Network LED steady red on duplicate IP, blinks red on lost connection.
// - Response defaults to freewheel; four stop settings enter fault state.
module fdl_diag #(
    parameter BLINK_CYC = `FDL_BLINK_CYC
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Link and network events
    input wire link_up,
    input wire link_100m,
    input wire link_traffic,
    input wire self_test,
    input wire ip_valid,
    input wire ip_invalid,
    input wire ip_duplicate,
    input wire repl_fail,
    input wire internal_err,
    input wire cmd_conn_open,
    input wire cmd_conn_lost,
    input wire eth_timeout,
    input wire monitored,
    // Network command word and references
    input wire [15:0] net_cmd_word,
    input wire [15:0] net_ref,
    input wire [15:0] hmi_ref,
    // Drive-side outputs
    output reg [15:0] cmd_word_q,
    output reg [15:0] ref_q,
    output reg run_fwd_q,
    output reg run_rev_q,
    output reg fault_reset_q,
    output reg fault_state_q,
    output reg [3:0] comm_interrupt_code,
    output reg internal_fault_flag,
    output reg [3:0] external_fault_code,
    // LEDs: [1] green, [0] yellow or red
    output reg [1:0] link_led_q,
    output reg [1:0] network_status_led
);
    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    reg [2:0] err_rsp_q;
    reg [1:0] control_mode_select;
    reg command_source_1;
    reg reference_source_1;
    reg conn_lost_q;
    wire phase;
    reg [1:0] link_led_d;
    reg [1:0] ns_led_d;
    reg [15:0] cmd_d;
    reg [15:0] ref_d;
    reg [31:0] rd_d;
    wire wr_en;
    wire rd_en;
    wire addr_bad;

    // Stop settings that move the drive into the fault state
    function enters_fault;
        input [2:0] rsp;
        begin
            enters_fault = (rsp == `FDL_RSP_FREEWHEEL) || (rsp == `FDL_RSP_RAMP) ||
                (rsp == `FDL_RSP_FAST) || (rsp == `FDL_RSP_DCINJ);
        end
    endfunction

    // Blink colour: on in phase, off out of phase
    function [1:0] blink;
        input [1:0] colour;
        input ph;
        begin
            blink = ph ? colour : `FDL_LED_OFF;
        end
    endfunction

    fdl_blink #(
        .HALF_CYC(BLINK_CYC)
    ) u_blink (
        .clk(clk),
        .rstn(rstn),
        .phase_q(phase)
    );

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    // Unmapped or unaligned offsets answer with an error and change nothing
    assign addr_bad = (paddr > `FDL_OFF_STAT) || (paddr[1:0] != 2'h0);

    always @* begin
        case (paddr)
            `FDL_OFF_CTRL: rd_d = {29'h0, err_rsp_q};
            `FDL_OFF_MODE: rd_d = {28'h0, reference_source_1, command_source_1,
                control_mode_select};
            `FDL_OFF_FAULT: rd_d = {19'h0, internal_fault_flag, external_fault_code,
                4'h0, comm_interrupt_code};
            `FDL_OFF_CMDW: rd_d = {cmd_word_q, ref_q};
            `FDL_OFF_STAT: rd_d = {26'h0, fault_state_q, conn_lost_q,
                network_status_led, link_led_q};
            default: rd_d = 32'h0;
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            err_rsp_q <= `FDL_RSP_RESET;
            control_mode_select <= `FDL_MODE_RESET;
            command_source_1 <= `FDL_SRC_ETH;
            reference_source_1 <= `FDL_SRC_ETH;
        end else begin
            // Ready rises in the access cycle so every transfer takes two cycles
            pready <= psel && !penable;
            pslverr <= psel && !penable && addr_bad;
            // Read data is captured in setup so prdata stays a plain register output
            if (rd_en) begin
                prdata <= rd_d;
            end
            if (wr_en && pready) begin
                case (paddr)
                    `FDL_OFF_CTRL: err_rsp_q <= pwdata[2:0];
                    `FDL_OFF_MODE: begin
                        // Mode code 3 is undefined; the old mode is kept rather than guessed
                        if (pwdata[1:0] != 2'h3) begin
                            control_mode_select <= pwdata[1:0];
                        end
                        command_source_1 <= pwdata[2];
                        reference_source_1 <= pwdata[3];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Fault codes
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            comm_interrupt_code <= 4'h0;
            external_fault_code <= 4'h0;
            fault_state_q <= 1'b0;
            conn_lost_q <= 1'b0;
        end else begin
            // Ignore disables monitoring outright
            if (eth_timeout && monitored && err_rsp_q != `FDL_RSP_IGNORE) begin
                comm_interrupt_code <= `FDL_ETH_TIMEOUT;
            end else begin
                comm_interrupt_code <= 4'h0;
            end
            // Settings 4 to 7 keep the drive running through an interruption
            fault_state_q <= eth_timeout && monitored && enters_fault(err_rsp_q);
            if (ip_duplicate) begin
                external_fault_code <= `FDL_EXT_DUP_IP;
            end else if (ip_invalid) begin
                external_fault_code <= `FDL_EXT_BAD_IP;
            end else if (repl_fail) begin
                external_fault_code <= `FDL_EXT_REPL;
            end else begin
                external_fault_code <= 4'h0;
            end
            // Lost-connection indication holds until a new connection opens
            // A loss in the same cycle as an open wins, so the red blink is not missed
            if (cmd_conn_lost) begin
                conn_lost_q <= 1'b1;
            end else if (cmd_conn_open) begin
                conn_lost_q <= 1'b0;
            end
        end
    end

    // Sticky: only a power cycle (reset) clears it
    always @(posedge clk) begin
        if (!rstn) begin
            internal_fault_flag <= 1'b0;
        end else if (internal_err) begin
            internal_fault_flag <= 1'b1;
        end
    end

    // ----------------------------------------
    // Command and reference source routing
    // ----------------------------------------
    always @* begin
        // Defaults keep every path assigned
        cmd_d = net_cmd_word;
        ref_d = net_ref;
        case (control_mode_select)
            `FDL_MODE_COMBINED: begin
                cmd_d = net_cmd_word;
                ref_d = net_ref;
            end
            `FDL_MODE_SPLIT: begin
                // No local command path is modelled, so an HMI command source yields zero
                cmd_d = (command_source_1 == `FDL_SRC_ETH) ? net_cmd_word : 16'h0;
                ref_d = (reference_source_1 == `FDL_SRC_ETH) ? net_ref : hmi_ref;
            end
            `FDL_MODE_IO: begin
                cmd_d = net_cmd_word;
                ref_d = hmi_ref;
            end
            default: begin
                cmd_d = 16'h0;
                ref_d = 16'h0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            cmd_word_q <= 16'h0;
            ref_q <= 16'h0;
            run_fwd_q <= 1'b0;
            run_rev_q <= 1'b0;
            fault_reset_q <= 1'b0;
        end else begin
            cmd_word_q <= cmd_d;
            ref_q <= ref_d;
            // I/O profile decodes only three loose bits; the whole word still passes through to cmd_word_q
            if (control_mode_select == `FDL_MODE_IO) begin
                run_fwd_q <= net_cmd_word[`FDL_IO_FWD];
                run_rev_q <= net_cmd_word[`FDL_IO_REV];
                fault_reset_q <= net_cmd_word[`FDL_IO_RST];
            end else begin
                run_fwd_q <= 1'b0;
                run_rev_q <= 1'b0;
                fault_reset_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // LEDs
    // ----------------------------------------
    // Self test outranks every other state so the power-on pattern is always seen
    always @* begin
        if (self_test) begin
            link_led_d = phase ? `FDL_LED_GRN : `FDL_LED_ALT;
        end else if (!link_up) begin
            link_led_d = `FDL_LED_OFF;
        end else if (link_traffic) begin
            link_led_d = blink(link_100m ? `FDL_LED_GRN : `FDL_LED_ALT, phase);
        end else begin
            link_led_d = link_100m ? `FDL_LED_GRN : `FDL_LED_ALT;
        end
    end

    always @* begin
        if (self_test) begin
            ns_led_d = phase ? `FDL_LED_GRN : `FDL_LED_ALT;
        end else if (ip_duplicate) begin
            ns_led_d = `FDL_LED_ALT;
        end else if (!ip_valid) begin
            ns_led_d = `FDL_LED_OFF;
        end else if (cmd_conn_open) begin
            ns_led_d = `FDL_LED_GRN;
        end else if (conn_lost_q) begin
            ns_led_d = blink(`FDL_LED_ALT, phase);
        end else begin
            ns_led_d = blink(`FDL_LED_GRN, phase);
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            link_led_q <= `FDL_LED_OFF;
            network_status_led <= `FDL_LED_OFF;
        end else begin
            link_led_q <= link_led_d;
            network_status_led <= ns_led_d;
        end
    end
endmodule

/* File: tb/fdl_diag_props.sv */
`timescale 1ns/1ps
// ------
// Checker
// ------
module fdl_diag_props #(
    parameter BLINK_CYC = 4
) (
    // Causes
    input wire clk,
    input wire rstn,
    input wire eth_timeout,
    input wire monitored,
    input wire internal_err,
    input wire ip_duplicate,
    input wire link_up,
    input wire self_test,
    // Results
    input wire [3:0] comm_interrupt_code,
    input wire internal_fault_flag,
    input wire [3:0] external_fault_code,
    input wire fault_state_q,
    input wire [1:0] link_led_q,
    input wire [1:0] network_status_led
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_CODE_CLEAR: assert property (
        !$past(eth_timeout) |-> comm_interrupt_code == 4'h0
    ) else $error("code not cleared");
    AST_CODE_CAUSE: assert property (
        comm_interrupt_code != 4'h0 |->
            comm_interrupt_code == 4'h1 && $past(eth_timeout && monitored)
    ) else $error("bad interrupt code");
    AST_FLAG_HOLD: assert property (
        internal_fault_flag |=> internal_fault_flag
    ) else $error("fault flag dropped");
    AST_FLAG_SET: assert property (
        $past(rstn && internal_err) |-> internal_fault_flag
    ) else $error("fault flag not set");
    AST_EXT_DUP: assert property (
        $past(rstn && ip_duplicate) |-> external_fault_code == 4'h2
    ) else $error("bad external code");
    AST_FAULT_CAUSE: assert property (
        fault_state_q |-> $past(eth_timeout && monitored)
    ) else $error("fault state without cause");
    AST_LINK_OFF: assert property (
        $past(rstn && !link_up && !self_test) |-> link_led_q == 2'h0
    ) else $error("link led lit without link");
    AST_NS_DUP: assert property (
        $past(rstn && ip_duplicate && !self_test) |-> network_status_led == 2'h1
    ) else $error("network led not red");

    cover property (comm_interrupt_code == 4'h1);
    cover property ($rose(link_led_q[1]) && link_up);
    cover property (network_status_led == 2'h1);
endmodule

bind fdl_diag fdl_diag_props #(.BLINK_CYC(BLINK_CYC)) u_props (
    .clk(clk), .rstn(rstn), .eth_timeout(eth_timeout), .monitored(monitored),
    .internal_err(internal_err), .ip_duplicate(ip_duplicate), .link_up(link_up),
    .self_test(self_test), .comm_interrupt_code(comm_interrupt_code),
    .internal_fault_flag(internal_fault_flag), .external_fault_code(external_fault_code),
    .fault_state_q(fault_state_q), .link_led_q(link_led_q),
    .network_status_led(network_status_led)
);

/* File: tb/fdl_net_ctrl.sv */
`timescale 1ns/1ps
module fdl_net_ctrl (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Bench control
    input wire connect,
    input wire silent,
    input wire [15:0] word_in,
    input wire [15:0] ref_in,
    // Toward the device
    output reg [15:0] net_cmd_word,
    output reg [15:0] net_ref,
    output reg cmd_conn_open,
    output reg cmd_conn_lost,
    output reg eth_timeout
);
    always @(posedge clk) begin
        if (!rstn) begin
            {net_cmd_word, net_ref, cmd_conn_open, cmd_conn_lost, eth_timeout} <= '0;
        end else begin
            cmd_conn_open <= connect;
            cmd_conn_lost <= cmd_conn_open & ~connect;
            eth_timeout <= silent;
            // Released lines keep changing so a stale word never passes for live data
            if (connect && !silent) begin
                net_cmd_word <= word_in;
                net_ref <= ref_in;
            end else begin
                net_cmd_word <= ~net_cmd_word;
                net_ref <= ~net_ref;
            end
        end
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "fdl_defines.vh"
module tb;
    logic clk, rstn, psel, penable, pwrite, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdata;
    logic link_up, link_100m, link_traffic, self_test, ip_valid, ip_invalid, ip_duplicate;
    logic repl_fail, internal_err, monitored, connect, silent;
    logic [15:0] word_in, ref_in, hmi_ref;
    wire [31:0] prdata;
    wire pready, pslverr, cmd_conn_open, cmd_conn_lost, eth_timeout;
    wire run_fwd_q, run_rev_q, fault_reset_q, fault_state_q, internal_fault_flag;
    wire [15:0] net_cmd_word, net_ref, cmd_word_q, ref_q;
    wire [3:0] comm_interrupt_code, external_fault_code;
    wire [1:0] link_led_q, network_status_led;
    integer err_count, checks, i;

    fdl_net_ctrl ctrl (
        .clk(clk), .rstn(rstn), .connect(connect), .silent(silent),
        .word_in(word_in), .ref_in(ref_in), .net_cmd_word(net_cmd_word),
        .net_ref(net_ref), .cmd_conn_open(cmd_conn_open),
        .cmd_conn_lost(cmd_conn_lost), .eth_timeout(eth_timeout)
    );
    fdl_diag #(.BLINK_CYC(4)) uut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_up(link_up), .link_100m(link_100m),
        .link_traffic(link_traffic), .self_test(self_test), .ip_valid(ip_valid),
        .ip_invalid(ip_invalid), .ip_duplicate(ip_duplicate), .repl_fail(repl_fail),
        .internal_err(internal_err), .cmd_conn_open(cmd_conn_open),
        .cmd_conn_lost(cmd_conn_lost), .eth_timeout(eth_timeout), .monitored(monitored),
        .net_cmd_word(net_cmd_word), .net_ref(net_ref), .hmi_ref(hmi_ref),
        .cmd_word_q(cmd_word_q), .ref_q(ref_q), .run_fwd_q(run_fwd_q),
        .run_rev_q(run_rev_q), .fault_reset_q(fault_reset_q),
        .fault_state_q(fault_state_q), .comm_interrupt_code(comm_interrupt_code),
        .internal_fault_flag(internal_fault_flag),
        .external_fault_code(external_fault_code), .link_led_q(link_led_q),
        .network_status_led(network_status_led)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task wrap_up;
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            err_count = err_count + 1;
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer n;
        begin
            {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
            @(posedge clk);
            penable <= 1'b1;
            for (n = 0; n < 16 && pready !== 1'b1; n++)
                @(posedge clk);
            if (pready !== 1'b1) begin
                err_count = err_count + 1;
                wrap_up;
            end
            rdata = prdata;
            rerr = pslverr;
            {psel, penable} <= 2'h0;
            @(posedge clk);
        end
    endtask

    // Collects which colour codes each led shows over several blink periods
    task led_case(input logic [3:0] el, input logic [3:0] en);
        logic [3:0] sl, sn;
        begin
            {sl, sn} = 8'h00;
            repeat (3) @(posedge clk);
            repeat (20) begin
                @(posedge clk);
                sl[link_led_q] = 1'b1;
                sn[network_status_led] = 1'b1;
            end
            chk("link_led", el, sl);
            chk("ns_led", en, sn);
        end
    endtask

    initial begin
        err_count = 0;
        checks = 0;
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, link_up, link_100m, link_traffic} = '0;
        {self_test, ip_valid, ip_invalid, ip_duplicate, repl_fail, internal_err} = '0;
        {monitored, connect, silent, word_in, ref_in, hmi_ref} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, `FDL_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0, rdata);
        apb(1'b0, `FDL_OFF_MODE, 32'h0);
        chk("mode", 32'hc, rdata);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        led_case(4'h1, 4'h1);
        {link_up, link_100m, ip_valid} <= 3'h7;
        led_case(4'h4, 4'h5);
        link_100m <= 1'b0;
        led_case(4'h2, 4'h5);
        link_traffic <= 1'b1;
        led_case(4'h3, 4'h5);
        link_100m <= 1'b1;
        led_case(4'h5, 4'h5);
        self_test <= 1'b1;
        led_case(4'h6, 4'h6);
        {self_test, connect} <= 2'h1;
        {word_in, ref_in, hmi_ref} <= {16'h0081, 16'h1234, 16'h5678};
        led_case(4'h5, 4'h4);
        apb(1'b1, `FDL_OFF_MODE, 32'he);
        repeat (3) @(posedge clk);
        chk("io_bits", 32'h5, {fault_reset_q, run_rev_q, run_fwd_q});
        chk("io_ref", 32'h5678, ref_q);
        apb(1'b1, `FDL_OFF_MODE, 32'hc);
        repeat (3) @(posedge clk);
        chk("combined", 32'h00811234, {cmd_word_q, ref_q});
        chk("comb_bits", 32'h0, {fault_reset_q, run_rev_q, run_fwd_q});
        apb(1'b1, `FDL_OFF_MODE, 32'h5);
        apb(1'b0, `FDL_OFF_CMDW, 32'h0);
        chk("split", 32'h00815678, rdata);
        apb(1'b1, `FDL_OFF_MODE, 32'h7);
        apb(1'b0, `FDL_OFF_MODE, 32'h0);
        chk("mode_refused", 32'h5, rdata);
        apb(1'b1, `FDL_OFF_MODE, 32'h1);
        apb(1'b0, `FDL_OFF_CMDW, 32'h0);
        chk("split_hmi", 32'h00005678, rdata);
        connect <= 1'b0;
        led_case(4'h5, 4'h3);
        ip_duplicate <= 1'b1;
        led_case(4'h5, 4'h2);
        for (i = 0; i < 3; i++) begin
            {repl_fail, ip_duplicate, ip_invalid} <= 3'h1 << i;
            repeat (3) @(posedge clk);
            chk("ext_code", 32'h1 << i, external_fault_code);
        end
        {repl_fail, monitored, silent} <= 3'h3;
        for (i = 0; i < 8; i++) begin
            apb(1'b1, `FDL_OFF_CTRL, i);
            repeat (3) @(posedge clk);
            chk("comm_code", i != 4, comm_interrupt_code);
            chk("fault_state", i < 4, fault_state_q);
        end
        silent <= 1'b0;
        repeat (3) @(posedge clk);
        chk("comm_clear", 32'h0, comm_interrupt_code);
        internal_err <= 1'b1;
        @(posedge clk);
        internal_err <= 1'b0;
        apb(1'b1, `FDL_OFF_FAULT, 32'hffffffff);
        repeat (3) @(posedge clk);
        chk("int_flag", 32'h1, internal_fault_flag);
        apb(1'b0, `FDL_OFF_FAULT, 32'h0);
        chk("fault_reg", 32'h1000, rdata);
        wrap_up;
    end
endmodule
